// ---- common/pixel_framer_regs.svh ----
// Purpose: Offsets, reset values and codes of the pixel output framer
// Assumes: Word-wide register port, one register per address
// Notes:   Definitions only
`ifndef PIXEL_FRAMER_REGS_SVH
`define PIXEL_FRAMER_REGS_SVH

// Register addresses
`define ADDR_CLOCK_GEN     8'h20
`define ADDR_LANE_TRAIN    8'h82
`define ADDR_SYNC_MARKER   8'h83
`define ADDR_DARK_CLASS    8'h84
`define ADDR_IMAGE_CLASS   8'h85
`define ADDR_CSUM_CLASS    8'h86
`define ADDR_STRAIN_CLASS  8'h87
`define ADDR_CRC_SEED      8'h88
`define ADDR_STATUS        8'h89

// Field positions
`define CLOCK_GEN_DEPTH_BIT 3
`define CRC_SEED_BIT        0

// Reset values
`define RST_LANE_TRAIN     10'h3a6
`define RST_SYNC_MARKER    7'h2a
`define RST_DARK_CLASS     10'h015
`define RST_IMAGE_CLASS    10'h035
`define RST_CSUM_CLASS     10'h059
`define RST_STRAIN_CLASS   10'h3a6

// Boundary kinds in the top three bits of a sync word
`define KIND_FRAME_OPEN    3'h5
`define KIND_FRAME_CLOSE   3'h6
`define KIND_ROW_OPEN      3'h1
`define KIND_ROW_CLOSE     3'h2

// Checksum generators without their top term
`define CRC_POLY10         10'h24f
`define CRC_POLY8          8'h4d

`endif

// ---- common/pixel_framer_pkg.sv ----
// Purpose: Types of the pixel output framer
// Assumes: Nothing
// Notes:   Constants live in pixel_framer_regs.svh
package pixel_framer_pkg;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_OPEN  = 7'h02,
    ST_WID1  = 7'h04,
    ST_DATA  = 7'h08,
    ST_CLOSE = 7'h10,
    ST_WID2  = 7'h20,
    ST_CRC   = 7'h40
  } seq_state_type;

endpackage : pixel_framer_pkg

// ---- logic/lane_crc.sv ----
// Purpose: Per-lane row checksum, 10-bit or 8-bit generator
// Assumes: One data word per enable, most significant bit first
// Notes:   Load and enable never coincide in the framer
`timescale 1ns/10ps
`include "pixel_framer_regs.svh"

module lane_crc (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // Control
  input  wire logic       en,
  input  wire logic       load,
  input  wire logic       seed_ones,
  input  wire logic       depth8,
  // Data and result
  input  wire logic [9:0] data,
  output logic      [9:0] crc
);

  logic [9:0] crc_q;
  logic [9:0] crc_d;
  logic [9:0] seed;

  function automatic logic [9:0] crc_step(input logic [9:0] c,
                                          input logic [9:0] d,
                                          input logic       d8);
    logic [9:0] r;
    logic       fb;
    r  = c;
    fb = 1'b0;
    if (!d8)
    begin
      for (int i = 9; i >= 0; i--)
      begin
        fb = r[9] ^ d[i];
        r  = {r[8:0], 1'b0} ^ (fb ? `CRC_POLY10 : 10'h000);
      end
    end
    else
    begin
      for (int i = 7; i >= 0; i--)
      begin
        fb      = r[7] ^ d[i];
        r[7:0]  = {r[6:0], 1'b0} ^ (fb ? `CRC_POLY8 : 8'h00);
      end
      r[9:8] = 2'b00;
    end
    crc_step = r;
  endfunction : crc_step

  // Seed width follows the word depth
  assign seed  = seed_ones ? (depth8 ? 10'h0ff : 10'h3ff) : 10'h000;
  assign crc_d = crc_step(crc_q, data, depth8);

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      crc_q <= 10'h000;
    else if (load)
      crc_q <= seed;
    else if (en)
      crc_q <= crc_d;
  end

  assign crc = crc_q;

endmodule : lane_crc

// ---- logic/pixel_output_sync_framer.sv ----
// Purpose: Sync lane, four data lanes and parallel port of the output stage
// Assumes: Row and kernel inputs come from logic on clock
// Notes:   word_clk is sampled; one output word per rising edge of it
`timescale 1ns/10ps
`include "pixel_framer_regs.svh"

module pixel_output_sync_framer (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rstn,
  // Register port
  input  wire logic         cfg_wr,
  input  wire logic [7:0]   cfg_addr,
  input  wire logic [9:0]   cfg_wdata,
  output logic      [9:0]   cfg_rdata,
  // Mode straps
  input  wire logic         parallel_sel,
  input  wire logic         subsample_en,
  input  wire logic         color_array,
  // Output word clock
  input  wire logic         word_clk,
  // Row request
  input  wire logic         row_req,
  input  wire logic [7:0]   row_win_mask,
  input  wire logic [7:0]   row_first_mask,
  input  wire logic [7:0]   row_last_mask,
  input  wire logic         row_dark,
  input  wire logic         row_frame_last,
  input  wire logic [7:0]   row_kernels,
  output logic              row_ack,
  // Kernel stream
  input  wire logic         kern_valid,
  input  wire logic [159:0] kern_pix,
  output logic              kern_ack,
  // Serial lanes
  output logic      [9:0]   sync_word,
  output logic      [9:0]   lane0_word,
  output logic      [9:0]   lane1_word,
  output logic      [9:0]   lane2_word,
  output logic      [9:0]   lane3_word,
  // Parallel port
  output logic      [9:0]   par_data,
  output logic              frame_valid,
  output logic              line_valid
);

  // Configuration
  logic [9:0] train_q;
  logic [6:0] marker_q;
  logic [9:0] dark_q;
  logic [9:0] image_q;
  logic [9:0] csum_q;
  logic [9:0] strain_q;
  logic       depth8_q;
  logic       seed_q;
  logic [9:0] rdata_q;
  logic [9:0] rdata_d;
  logic       depth8;

  // Word clock sampling
  logic       wclk_s1_q;
  logic       wclk_s2_q;
  logic       wclk_s3_q;
  logic       word_en;

  // Sequencer
  pixel_framer_pkg::seq_state_type state_q;
  pixel_framer_pkg::seq_state_type state_d;
  logic [2:0]   wcnt_q;
  logic [7:0]   kleft_q;
  logic         kodd_q;
  logic         have_k_q;
  logic [159:0] kbuf_q;
  logic [2:0]   hi_q;
  logic [2:0]   open_kind_q;
  logic [2:0]   close_kind_q;
  logic         dark_q_row;
  logic         flast_q;
  logic [2:0]   win_hi;
  logic [2:0]   last_w;
  logic         row_take;
  logic         kern_take;
  logic         data_word;
  logic         kern_done;
  logic         last_k;
  logic         fetch_state;
  logic         in_crc;
  logic         idle_st;

  // Outputs
  logic [9:0] sync_q;
  logic [9:0] sync_d;
  logic [9:0] lane_q [4];
  logic [9:0] lane_d [4];
  logic [9:0] par_q;
  logic       fv_q;
  logic       fv_d;
  logic       lv_q;
  logic       row_ack_q;
  logic       kern_ack_q;

  function automatic logic [9:0] narrow(input logic [9:0] x,
                                        input logic       d8);
    narrow = d8 ? {2'b00, x[9:2]} : x;
  endfunction : narrow

  function automatic logic [9:0] bound(input logic [2:0] kind,
                                       input logic [6:0] mk,
                                       input logic       d8);
    bound = d8 ? {2'b00, kind, mk[6:2]} : {kind, mk};
  endfunction : bound

  function automatic logic [9:0] wid(input logic [2:0] id,
                                     input logic       d8);
    wid = d8 ? {5'b00000, id, 2'b00} : {7'h00, id};
  endfunction : wid

  function automatic logic [2:0] highest(input logic [7:0] m);
    logic [2:0] h;
    h = 3'h0;
    for (int i = 0; i < 8; i++)
    begin
      if (m[i])
        h = 3'(i);
    end
    highest = h;
  endfunction : highest

  // Pixel position inside the kernel for output slot k
  function automatic logic [3:0] pix_pos(input logic [2:0] k,
                                         input logic       odd,
                                         input logic       sub,
                                         input logic       col);
    if (!sub)
      pix_pos = odd ? {1'b0, 3'h7 - k} : {1'b0, k};
    else if (col)
      pix_pos = {k[2:1], 1'b0, k[0]};
    else
      pix_pos = {k, 1'b0};
  endfunction : pix_pos

  // Register writes
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      train_q  <= `RST_LANE_TRAIN;
      marker_q <= `RST_SYNC_MARKER;
      dark_q   <= `RST_DARK_CLASS;
      image_q  <= `RST_IMAGE_CLASS;
      csum_q   <= `RST_CSUM_CLASS;
      strain_q <= `RST_STRAIN_CLASS;
      depth8_q <= 1'b0;
      seed_q   <= 1'b0;
    end
    else if (cfg_wr)
    begin
      case (cfg_addr)
        `ADDR_LANE_TRAIN:   train_q  <= cfg_wdata;
        `ADDR_SYNC_MARKER:  marker_q <= cfg_wdata[6:0];
        `ADDR_DARK_CLASS:   dark_q   <= cfg_wdata;
        `ADDR_IMAGE_CLASS:  image_q  <= cfg_wdata;
        `ADDR_CSUM_CLASS:   csum_q   <= cfg_wdata;
        `ADDR_STRAIN_CLASS: strain_q <= cfg_wdata;
        `ADDR_CLOCK_GEN:    depth8_q <= cfg_wdata[`CLOCK_GEN_DEPTH_BIT];
        `ADDR_CRC_SEED:     seed_q   <= cfg_wdata[`CRC_SEED_BIT];
        default:            seed_q   <= seed_q;
      endcase
    end
  end

  // Read mux, unmapped addresses read zero
  assign rdata_d =
    (cfg_addr == `ADDR_LANE_TRAIN)   ? train_q :
    (cfg_addr == `ADDR_SYNC_MARKER)  ? {3'h0, marker_q} :
    (cfg_addr == `ADDR_DARK_CLASS)   ? dark_q :
    (cfg_addr == `ADDR_IMAGE_CLASS)  ? image_q :
    (cfg_addr == `ADDR_CSUM_CLASS)   ? csum_q :
    (cfg_addr == `ADDR_STRAIN_CLASS) ? strain_q :
    (cfg_addr == `ADDR_CLOCK_GEN)    ? {6'h00, depth8_q, 3'h0} :
    (cfg_addr == `ADDR_CRC_SEED)     ? {9'h000, seed_q} :
    (cfg_addr == `ADDR_STATUS)       ? {1'b0, fv_q, lv_q, state_q} :
                                       10'h000;

  // Parallel port has no 8-bit mode
  assign depth8 = depth8_q & ~parallel_sel;

  // Word clock comes from outside; the second and third stages are read for its rising edge
  assign word_en = wclk_s2_q & ~wclk_s3_q;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wclk_s1_q <= 1'b0;
      wclk_s2_q <= 1'b0;
      wclk_s3_q <= 1'b0;
    end
    else
    begin
      wclk_s1_q <= word_clk;
      wclk_s2_q <= wclk_s1_q;
      wclk_s3_q <= wclk_s2_q;
    end
  end

  // Sequencer decode
  assign win_hi      = highest(row_win_mask);
  assign last_w      = parallel_sel ? 3'h7 : 3'h1;
  assign data_word   = (state_q == pixel_framer_pkg::ST_DATA) && have_k_q;
  assign kern_done   = data_word && (wcnt_q == last_w);
  assign last_k      = (kleft_q == 8'h01);
  assign in_crc      = (state_q == pixel_framer_pkg::ST_CRC);
  assign idle_st     = (state_q == pixel_framer_pkg::ST_IDLE);
  assign row_take    = word_en && row_req && (row_kernels != 8'h00) &&
                       (state_q == pixel_framer_pkg::ST_IDLE);
  assign fetch_state = (state_q == pixel_framer_pkg::ST_OPEN) ||
                       (state_q == pixel_framer_pkg::ST_WID1) ||
                       (state_q == pixel_framer_pkg::ST_DATA);
  // Prefetch during the boundary words hides kernel latency
  assign kern_take   = fetch_state && !have_k_q && kern_valid &&
                       (kleft_q != 8'h00);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      pixel_framer_pkg::ST_IDLE:
        if (row_take)
          state_d = pixel_framer_pkg::ST_OPEN;
      pixel_framer_pkg::ST_OPEN:
        if (word_en)
          state_d = pixel_framer_pkg::ST_WID1;
      pixel_framer_pkg::ST_WID1:
        if (word_en)
          state_d = pixel_framer_pkg::ST_DATA;
      pixel_framer_pkg::ST_DATA:
        if (word_en && kern_done && last_k)
          state_d = parallel_sel ? pixel_framer_pkg::ST_CRC
                                 : pixel_framer_pkg::ST_CLOSE;
      pixel_framer_pkg::ST_CLOSE:
        if (word_en)
          state_d = pixel_framer_pkg::ST_WID2;
      pixel_framer_pkg::ST_WID2:
        if (word_en)
          state_d = pixel_framer_pkg::ST_CRC;
      pixel_framer_pkg::ST_CRC:
        if (word_en)
          state_d = pixel_framer_pkg::ST_IDLE;
      default:
        state_d = pixel_framer_pkg::ST_IDLE;
    endcase
  end

  // Sync lane word for the current state
  always_comb
  begin
    case (state_q)
      pixel_framer_pkg::ST_OPEN:
        sync_d = bound(open_kind_q, marker_q, depth8);
      pixel_framer_pkg::ST_WID1,
      pixel_framer_pkg::ST_WID2:
        sync_d = wid(hi_q, depth8);
      pixel_framer_pkg::ST_DATA:
        sync_d = !have_k_q ? narrow(strain_q, depth8) :
                 dark_q_row ? narrow(dark_q, depth8)
                            : narrow(image_q, depth8);
      pixel_framer_pkg::ST_CLOSE:
        sync_d = bound(close_kind_q, marker_q, depth8);
      pixel_framer_pkg::ST_CRC:
        sync_d = narrow(csum_q, depth8);
      default:
        sync_d = narrow(strain_q, depth8);
    endcase
  end

  // Frame strobe rises with the first row, falls after the last checksum
  assign fv_d = row_take ? 1'b1 :
                (idle_st && flast_q) ? 1'b0 : fv_q;

  // Data lanes with their own checksum registers
  for (genvar l = 0; l < 4; l++)
  begin : g_lane
    logic [2:0] slot;
    logic [3:0] pos;
    logic [9:0] pix;
    logic [9:0] crc;
    assign slot = parallel_sel ? wcnt_q : {2'(l), wcnt_q[0]};
    assign pos  = pix_pos(slot, kodd_q, subsample_en, color_array);
    assign pix  = kbuf_q[pos * 10 +: 10];
    assign lane_d[l] = in_crc ? crc :
                       data_word ? narrow(pix, depth8)
                                 : narrow(train_q, depth8);

    lane_crc u_crc (
      .clock     (clock),
      .rstn      (rstn),
      .en        (word_en && data_word),
      .load      (row_take),
      .seed_ones (seed_q),
      .depth8    (depth8),
      .data      (lane_d[l]),
      .crc       (crc)
    );
  end

  // Sequencer state
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q      <= pixel_framer_pkg::ST_IDLE;
      wcnt_q       <= 3'h0;
      kleft_q      <= 8'h00;
      kodd_q       <= 1'b0;
      hi_q         <= 3'h0;
      open_kind_q  <= `KIND_ROW_OPEN;
      close_kind_q <= `KIND_ROW_CLOSE;
      dark_q_row   <= 1'b0;
      flast_q      <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (row_take)
      begin
        kleft_q      <= row_kernels;
        kodd_q       <= 1'b0;
        wcnt_q       <= 3'h0;
        hi_q         <= win_hi;
        open_kind_q  <= row_first_mask[win_hi] ? `KIND_FRAME_OPEN
                                               : `KIND_ROW_OPEN;
        close_kind_q <= row_last_mask[win_hi] ? `KIND_FRAME_CLOSE
                                              : `KIND_ROW_CLOSE;
        dark_q_row   <= row_dark;
        flast_q      <= row_frame_last;
      end
      else if (word_en && data_word)
      begin
        wcnt_q <= kern_done ? 3'h0 : wcnt_q + 3'h1;
        if (kern_done)
        begin
          kleft_q <= kleft_q - 8'h01;
          kodd_q  <= ~kodd_q;
        end
      end
    end
  end

  // Kernel holding register
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      have_k_q <= 1'b0;
      kbuf_q   <= 160'h0;
    end
    else if (kern_take)
    begin
      have_k_q <= 1'b1;
      kbuf_q   <= kern_pix;
    end
    else if (word_en && kern_done)
      have_k_q <= 1'b0;
  end

  // All lanes change on the same word enable
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sync_q <= `RST_STRAIN_CLASS;
      par_q  <= `RST_LANE_TRAIN;
      fv_q   <= 1'b0;
      lv_q   <= 1'b0;
      for (int i = 0; i < 4; i++)
        lane_q[i] <= `RST_LANE_TRAIN;
    end
    else if (word_en)
    begin
      sync_q <= sync_d;
      par_q  <= lane_d[0];
      fv_q   <= fv_d;
      lv_q   <= data_word;
      for (int i = 0; i < 4; i++)
        lane_q[i] <= lane_d[i];
    end
  end

  // Handshake pulses and read data
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      row_ack_q  <= 1'b0;
      kern_ack_q <= 1'b0;
      rdata_q    <= 10'h000;
    end
    else
    begin
      row_ack_q  <= row_take;
      kern_ack_q <= kern_take;
      rdata_q    <= rdata_d;
    end
  end

  assign cfg_rdata   = rdata_q;
  assign row_ack     = row_ack_q;
  assign kern_ack    = kern_ack_q;
  assign sync_word   = sync_q;
  assign lane0_word  = lane_q[0];
  assign lane1_word  = lane_q[1];
  assign lane2_word  = lane_q[2];
  assign lane3_word  = lane_q[3];
  assign par_data    = par_q;
  assign frame_valid = fv_q;
  assign line_valid  = lv_q;

endmodule : pixel_output_sync_framer

// ---- tb/framer_checker.sv ----
// Purpose: Port checks of the pixel output framer
// Assumes: Shadow registers follow writes on the register port
// Notes:   Lane word checks other than the slot alignment and checksum slot checks wait out a quiet time after any write
`timescale 1ns/10ps
`include "pixel_framer_regs.svh"

module framer_checker (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rstn,
  // Register port
  input wire logic       cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [9:0] cfg_wdata,
  input wire logic [9:0] cfg_rdata,
  // Lanes and strobes
  input wire logic       parallel_sel,
  input wire logic [9:0] sync_word,
  input wire logic [9:0] lane0_word,
  input wire logic [9:0] lane1_word,
  input wire logic       frame_valid,
  input wire logic       line_valid
);
  logic [9:0] sh_q [8];
  logic       d8_q;
  logic [3:0] quiet_q;

  function automatic logic [9:0] cut(input logic [9:0] x);
    return d8_q ? {2'h0, x[9:2]} : x;
  endfunction : cut

  wire       quiet = quiet_q == 4'hf;
  wire       ser   = !parallel_sel && quiet;
  wire [2:0] kind  = d8_q ? sync_word[7:5] : sync_word[9:7];
  wire       cls   = sync_word == cut(sh_q[4]) || sync_word == cut(sh_q[5])
                  || sync_word == cut(sh_q[6]) || sync_word == cut(sh_q[7]);
  wire       bnd   = (kind == 3'h1 || kind == 3'h2 || kind == 3'h5
                  || kind == 3'h6) && !cls;

  // Writes make the shadow run ahead of the next word slot
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      sh_q    <= '{10'h0, 10'h0, `RST_LANE_TRAIN, 10'(`RST_SYNC_MARKER),
                   `RST_DARK_CLASS, `RST_IMAGE_CLASS, `RST_CSUM_CLASS,
                   `RST_STRAIN_CLASS};
      d8_q    <= 1'h0;
      quiet_q <= 4'h0;
    end
    else
    begin
      if (cfg_wr && cfg_addr[7:3] == 5'h10)
        sh_q[cfg_addr[2:0]] <= cfg_wdata;
      if (cfg_wr && cfg_addr == `ADDR_CLOCK_GEN)
        d8_q <= cfg_wdata[`CLOCK_GEN_DEPTH_BIT];
      quiet_q <= cfg_wr ? 4'h0 : quiet_q + {3'h0, !quiet};
    end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence out_held;
    $stable({sync_word, lane0_word, lane1_word, line_valid})[*4];
  endsequence
  sequence row_span;
    (frame_valid && line_valid)[*8];
  endsequence

  AST_SLOT_ALIGN: assert property (
    $changed({sync_word, lane0_word, line_valid}) |=> out_held)
    else $error("lane words moved inside a word slot");
  AST_CLASS_WORD: assert property (
    ser && line_valid |-> sync_word == cut(sh_q[5]) || sync_word == cut(sh_q[4]))
    else $error("pixel slot without pixel class word");
  AST_IDLE_TRAIN: assert property (
    ser && !line_valid && sync_word == cut(sh_q[7])
    |-> lane0_word == cut(sh_q[2]) && lane1_word == cut(sh_q[2]))
    else $error("idle lanes not sending training");
  AST_MARKER: assert property (
    ser && bnd |-> sync_word == (d8_q ? {2'h0, kind, sh_q[3][6:2]}
                                      : {kind, sh_q[3][6:0]}))
    else $error("boundary word marker wrong");
  AST_WIN_ID: assert property (
    ser && $changed(sync_word) && $past(bnd)
    |-> (d8_q ? sync_word[9:5] == 5'h0 && sync_word[1:0] == 2'h0
              : sync_word[9:3] == 7'h0))
    else $error("boundary word not followed by window id");
  AST_DEPTH8: assert property (
    quiet && d8_q |-> {sync_word[9:8], lane0_word[9:8]} == 4'h0)
    else $error("upper bits set in 8-bit mode");
  AST_CSUM_SLOT: assert property (
    !parallel_sel && $fell(line_valid) |-> ##[12:20] sync_word == cut(sh_q[6]))
    else $error("checksum class word missing");
  AST_PAR_FRAME: assert property (
    parallel_sel && $fell(line_valid) |-> frame_valid)
    else $error("frame strobe fell before checksum");
  AST_PAR_ROW: assert property (
    parallel_sel && $rose(line_valid) |-> row_span)
    else $error("row strobe too short or outside frame");
  AST_READ_BACK: assert property (
    !$past(cfg_wr) && $past(cfg_addr) == `ADDR_IMAGE_CLASS
    |-> cfg_rdata == sh_q[5])
    else $error("register read back wrong");
endmodule : framer_checker

bind pixel_output_sync_framer framer_checker chk (.clock, .rstn, .cfg_wr,
  .cfg_addr, .cfg_wdata, .cfg_rdata, .parallel_sel, .sync_word, .lane0_word,
  .lane1_word, .frame_valid, .line_valid);

// ---- tb/frame_receiver.sv ----
// Purpose: Receiver at the far end of the lanes
// Assumes: Outputs settle long before the next word clock edge
// Notes:   Logs every word slot for the bench
`timescale 1ns/10ps
`include "pixel_framer_regs.svh"

module frame_receiver (
  // Word clock and seed
  input wire logic       word_clk,
  input wire logic       seed_ones,
  // Lanes
  input wire logic [9:0] sync_word,
  input wire logic [9:0] lane0_word,
  input wire logic [9:0] lane1_word,
  input wire logic [9:0] lane2_word,
  input wire logic [9:0] lane3_word,
  input wire logic [9:0] par_data,
  // Strobes
  input wire logic       line_valid,
  input wire logic       frame_valid
);
  logic [61:0] log_q [$];
  logic [9:0]  par_calc = 10'h0;
  logic [9:0]  par_csum = 10'h0;
  logic        lv_q     = 1'h0;

  // Shift left, most significant bit first
  function automatic logic [9:0] crc_step(input logic [9:0] c, d,
                                          input logic d8);
    logic fb;
    for (int i = (d8 ? 7 : 9); i >= 0; i--)
    begin
      fb = c[d8 ? 7 : 9] ^ d[i];
      c  = d8 ? {2'h0, c[6:0], 1'h0} : {c[8:0], 1'h0};
      if (fb)
        c = c ^ (d8 ? {2'h0, `CRC_POLY8} : `CRC_POLY10);
    end
    return c;
  endfunction : crc_step

  always @(posedge word_clk)
  begin
    log_q.push_back({frame_valid, line_valid, par_data, sync_word,
                     lane3_word, lane2_word, lane1_word, lane0_word});
    if (line_valid)
      par_calc = crc_step(lv_q ? par_calc : {10{seed_ones}}, par_data, 1'h0);
    if (!line_valid && lv_q)
      par_csum = par_data;
    lv_q = line_valid;
  end
endmodule : frame_receiver

// ---- tb/tb.sv ----
// Purpose: Bench of the pixel output framer
// Assumes: Word clock runs free, kernels are offered at once
// Notes:   Row output is judged from the receiver slot log
`timescale 1ns/10ps
`include "pixel_framer_regs.svh"

module tb;
  logic         clock = 1'h0, rstn = 1'h0, cfg_wr = 1'h0, word_clk = 1'h0;
  logic         parallel_sel = 1'h0, subsample_en = 1'h0, color_array = 1'h0;
  logic         row_req = 1'h0, row_dark = 1'h0, row_frame_last = 1'h0;
  logic         kern_valid = 1'h0, seed1 = 1'h0;
  logic [7:0]   cfg_addr = 8'h0, row_win_mask = 8'h0, row_first_mask = 8'h0;
  logic [7:0]   row_last_mask = 8'h0, row_kernels = 8'h0;
  logic [9:0]   cfg_wdata = 10'h0, cfg_rdata, sync_word, par_data;
  logic [9:0]   lane0_word, lane1_word, lane2_word, lane3_word;
  logic [159:0] kern_pix = 160'h0;
  logic         row_ack, kern_ack, frame_valid, line_valid;
  int           err_total = 0, num_checks = 0, cyc = 0;
  logic [7:0]   ra [6] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87};
  logic [9:0]   rv [6] = '{10'h3a6, 10'h02a, 10'h015, 10'h035, 10'h059, 10'h3a6};

  pixel_output_sync_framer DUT (.clock, .rstn, .cfg_wr, .cfg_addr, .cfg_wdata,
    .cfg_rdata, .parallel_sel, .subsample_en, .color_array, .word_clk,
    .row_req, .row_win_mask, .row_first_mask, .row_last_mask, .row_dark,
    .row_frame_last, .row_kernels, .row_ack, .kern_valid, .kern_pix, .kern_ack,
    .sync_word, .lane0_word, .lane1_word, .lane2_word, .lane3_word, .par_data,
    .frame_valid, .line_valid);
  frame_receiver rx (.word_clk, .seed_ones(seed1), .sync_word, .lane0_word,
    .lane1_word, .lane2_word, .lane3_word, .par_data, .line_valid,
    .frame_valid);

  always #12.5 clock = ~clock;
  // Odd start keeps the word clock out of phase with the system clock
  initial #37 forever #100 word_clk = ~word_clk;

  task automatic complete_run;
    if (err_total == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      complete_run();
    end
  end

  task automatic check(input logic [9:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic till(ref logic s, input logic v);
    for (int t = 0; t < 3000 && s !== v; t++)
      @(posedge clock);
  endtask : till

  task automatic wr(input logic [7:0] a, input logic [9:0] d);
    @(posedge clock);
    cfg_wr <= 1'h1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clock);
    cfg_wr <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [9:0] exp);
    @(posedge clock);
    cfg_addr <= a;
    repeat (2) @(posedge clock);
    check(cfg_rdata, exp);
  endtask : rd

  function automatic logic [9:0] pv(input int k, p);
    return 10'(k * 97 + p * 61 + 17);
  endfunction : pv

  function automatic int pos(input int j, k);
    if (subsample_en)
      return color_array ? 4 * (k / 2) + k % 2 : 2 * k;
    return j % 2 ? 7 - k : k;
  endfunction : pos

  task automatic row(input logic [7:0] win, first, last,
                     input logic dark, flast, input int nk);
    logic [159:0] kp;
    rx.log_q.delete();
    @(posedge clock);
    row_win_mask <= win;
    row_first_mask <= first;
    row_last_mask <= last;
    row_dark <= dark;
    row_frame_last <= flast;
    row_kernels <= 8'(nk);
    row_req <= 1'h1;
    till(row_ack, 1'h1);
    row_req <= 1'h0;
    for (int k = 0; k < nk; k++)
    begin
      for (int p = 0; p < 16; p++)
        kp[p*10+:10] = pv(k, p);
      @(posedge clock);
      kern_pix <= kp;
      kern_valid <= 1'h1;
      till(kern_ack, 1'h1);
      kern_valid <= 1'h0;
    end
    till(line_valid, 1'h1);
    till(line_valid, 1'h0);
    // Close, id and checksum slots follow, only the checksum in parallel mode, then idle
    repeat (5) @(posedge word_clk);
    @(posedge clock);
  endtask : row

  task automatic chk_row(input logic [9:0] op, id, cl, cs, cx, tr,
                         input logic d8, input int nk);
    logic [61:0] r;
    logic [9:0]  c [4];
    logic [9:0]  e;
    int          i;
    i = 0;
    while (i < rx.log_q.size() && rx.log_q[i][49:40] !== op)
      i++;
    foreach (c[l])
      c[l] = seed1 ? (d8 ? 10'h0ff : 10'h3ff) : 10'h0;
    check(rx.log_q[i][49:40], op);
    check(rx.log_q[i][9:0], tr);
    check(rx.log_q[i+1][49:40], id);
    for (int s = 0; s < 2 * nk; s++)
    begin
      r = rx.log_q[i+2+s];
      check(r[49:40], cl);
      for (int l = 0; l < 4; l++)
      begin
        e = pv(s / 2, pos(s / 2, 2 * l + s % 2));
        e = d8 ? {2'h0, e[9:2]} : e;
        check(r[l*10+:10], e);
        c[l] = rx.crc_step(c[l], e, d8);
      end
    end
    check(rx.log_q[i+2+2*nk][49:40], cx);
    check(rx.log_q[i+3+2*nk][49:40], id);
    r = rx.log_q[i+4+2*nk];
    check(r[49:40], cs);
    foreach (c[l])
      check(r[l*10+:10], c[l]);
  endtask : chk_row

  task automatic chk_par(input logic last);
    logic [61:0] r;
    logic [9:0]  c;
    int          i;
    i = 0;
    c = 10'h0;
    while (i < rx.log_q.size() && rx.log_q[i][60] !== 1'h1)
      i++;
    for (int k = 0; k < 8; k++)
    begin
      r = rx.log_q[i+k];
      check(r[59:50], pv(0, pos(0, k)));
      check({9'h0, r[61]}, 10'h1);
      c = rx.crc_step(c, r[59:50], 1'h0);
    end
    check(rx.log_q[i+8][59:50], c);
    check(rx.par_csum, c);
    check(rx.par_calc, c);
    check({8'h0, rx.log_q[i+8][61:60]}, 10'h2);
    check({9'h0, rx.log_q[i+9][61]}, {9'h0, !last});
  endtask : chk_par

  initial
  begin
    repeat (20) @(posedge clock);
    rstn <= 1'h1;
    @(posedge clock);
    check(sync_word, 10'h3a6);
    check(lane3_word, 10'h3a6);
    check({8'h0, frame_valid, line_valid}, 10'h0);
    foreach (ra[n])
      rd(ra[n], rv[n]);
    rd(`ADDR_STATUS, 10'h001);
    wr(`ADDR_IMAGE_CLASS, 10'h123);
    wr(8'h01, 10'h3ff);
    rd(`ADDR_IMAGE_CLASS, 10'h123);
    rd(8'h01, 10'h0);
    row(8'h0a, 8'h08, 8'h08, 1'h0, 1'h0, 1);
    chk_row(10'h2aa, 10'h003, 10'h123, 10'h059, 10'h32a, 10'h3a6, 1'h0, 1);
    wr(`ADDR_CRC_SEED, 10'h001);
    seed1 = 1'h1;
    wr(`ADDR_SYNC_MARKER, 10'h015);
    row(8'h01, 8'h00, 8'h00, 1'h1, 1'h0, 2);
    chk_row(10'h095, 10'h000, 10'h015, 10'h059, 10'h115, 10'h3a6, 1'h0, 2);
    wr(`ADDR_CLOCK_GEN, 10'h008);
    rd(`ADDR_CLOCK_GEN, 10'h008);
    subsample_en <= 1'h1;
    row(8'h80, 8'h80, 8'h00, 1'h0, 1'h0, 1);
    chk_row(10'h0a5, 10'h01c, 10'h048, 10'h016, 10'h045, 10'h0e9, 1'h1, 1);
    wr(`ADDR_CLOCK_GEN, 10'h000);
    wr(`ADDR_CRC_SEED, 10'h000);
    seed1 = 1'h0;
    parallel_sel <= 1'h1;
    color_array <= 1'h1;
    row(8'h01, 8'h01, 8'h00, 1'h0, 1'h0, 1);
    chk_par(1'h0);
    row(8'h01, 8'h00, 8'h01, 1'h0, 1'h1, 1);
    chk_par(1'h1);
    complete_run();
  end
endmodule : tb
